// [shared/etp_pkg.sv]
`default_nettype none
package etp_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTL0 = 8'h00;
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_OUTCTL = 8'h08;
  localparam logic [7:0] OFS_CAPCTL = 8'h0c;
  localparam logic [7:0] OFS_TRGCTL = 8'h10;
  localparam logic [7:0] OFS_OPT = 8'h14;
  localparam logic [7:0] OFS_PER = 8'h18;
  localparam logic [7:0] OFS_DUTY = 8'h1c;
  localparam logic [7:0] OFS_CNT = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTL0_CE_BIT = 0;
  localparam int CTL1_MD_LSB = 0;
  localparam int CTL1_EST_BIT = 6;
  localparam int OUT_TOE_BIT = 0;
  localparam int OUT_TOL_BIT = 1;
  localparam int OUT_POE_BIT = 2;
  localparam int OUT_POL_BIT = 3;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_WAIT_BIT = 1;
  // ------------------------------------------------------------
  // codes and reset values
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_EXT_TRIG = 3'h2;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [15:0] CNT_IDLE = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_CMP = 16'h0000;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_STOP, ST_WAIT, ST_RUN} etp_state_t;
  typedef struct packed {
    logic pwm;
    logic toggle;
  } etp_pins_t;
  typedef struct packed {
    logic period;
    logic duty;
  } etp_irq_t;
endpackage
`default_nettype wire

// [hdl/etp_edge_trig.sv]
`default_nettype none
module etp_edge_trig (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // trigger pin and edge choice
  input wire logic trig_in,
  input wire logic [1:0] edge_sel,
  // one-cycle trigger
  output logic trig_pulse
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic rise;
  logic fall;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= trig_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      trig_pulse <= 1'b0;
    end else begin
      case (edge_sel)
        etp_pkg::EDGE_RISE: trig_pulse <= rise;
        etp_pkg::EDGE_FALL: trig_pulse <= fall;
        etp_pkg::EDGE_BOTH: trig_pulse <= rise | fall;
        default: trig_pulse <= 1'b0;
      endcase
    end
  end
endmodule // etp_edge_trig
`default_nettype wire

// [hdl/etp_cmp_buf.sv]
`default_nettype none
module etp_cmp_buf #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // software side
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  // transfer strobe
  input wire logic load,
  // values
  output logic [W-1:0] reg_q,
  output logic [W-1:0] buf_q
);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_q <= W'(etp_pkg::RST_CMP);
    end else if (wr_en) begin
      reg_q <= wr_data;
    end
  end

  // compare value only moves at a counter clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      buf_q <= W'(etp_pkg::RST_CMP);
    end else if (load) begin
      buf_q <= reg_q;
    end
  end
endmodule // etp_cmp_buf
`default_nettype wire

// [hdl/etp_timer.sv]
`default_nettype none
module etp_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // external trigger
  input wire logic ext_trig_in,
  // timer pins
  output etp_pkg::etp_pins_t pins_o,
  // match events
  output etp_pkg::etp_irq_t irq_o
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [CNT_W-1:0] merge_lanes(
    input logic [CNT_W-1:0] old,
    input logic [31:0] data,
    input logic [3:0] sel
  );
    logic [CNT_W-1:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = data[7:0];
    end
    if (sel[1]) begin
      r[CNT_W-1:8] = data[CNT_W-1:8];
    end
    return r;
  endfunction

  function automatic logic [31:0] widen8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic req;
  logic wr;
  logic wr_ctl0;
  logic wr_ctl1;
  logic wr_out;
  logic wr_cap;
  logic wr_trg;
  logic wr_opt;
  logic wr_per;
  logic wr_duty;

  // write commits at the edge that raises ack
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;

  always_comb begin
    wr_ctl0 = 1'b0;
    wr_ctl1 = 1'b0;
    wr_out = 1'b0;
    wr_cap = 1'b0;
    wr_trg = 1'b0;
    wr_opt = 1'b0;
    wr_per = 1'b0;
    wr_duty = 1'b0;
    if (wb_adr_i == etp_pkg::OFS_CTL0) begin
      wr_ctl0 = wr & wb_sel_i[0];
    end else if (wb_adr_i == etp_pkg::OFS_CTL1) begin
      wr_ctl1 = wr & wb_sel_i[0];
    end else if (wb_adr_i == etp_pkg::OFS_OUTCTL) begin
      wr_out = wr & wb_sel_i[0];
    end else if (wb_adr_i == etp_pkg::OFS_CAPCTL) begin
      wr_cap = wr & wb_sel_i[0];
    end else if (wb_adr_i == etp_pkg::OFS_TRGCTL) begin
      wr_trg = wr & wb_sel_i[0];
    end else if (wb_adr_i == etp_pkg::OFS_OPT) begin
      wr_opt = wr & wb_sel_i[0];
    end else if (wb_adr_i == etp_pkg::OFS_PER) begin
      wr_per = wr & (|wb_sel_i[1:0]);
    end else if (wb_adr_i == etp_pkg::OFS_DUTY) begin
      wr_duty = wr & (|wb_sel_i[1:0]);
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  logic [7:0] ctl0_reg;
  logic [7:0] ctl1_reg;
  logic [7:0] outctl_reg;
  logic [7:0] capctl_reg;
  logic [7:0] trgctl_reg;
  logic [7:0] opt_reg;
  logic sw_trig_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctl0_reg <= etp_pkg::RST_BYTE;
      ctl1_reg <= etp_pkg::RST_BYTE;
      outctl_reg <= etp_pkg::RST_BYTE;
      trgctl_reg <= etp_pkg::RST_BYTE;
    end else begin
      if (wr_ctl0) begin
        ctl0_reg <= wb_dat_i[7:0];
      end
      if (wr_ctl1) begin
        ctl1_reg <= wb_dat_i[7:0] & ~(8'h01 << etp_pkg::CTL1_EST_BIT);
      end
      if (wr_out) begin
        outctl_reg <= wb_dat_i[7:0];
      end
      if (wr_trg) begin
        trgctl_reg <= wb_dat_i[7:0];
      end
    end
  end

  // stored for software only, never read by the counter logic
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      capctl_reg <= etp_pkg::RST_BYTE;
      opt_reg <= etp_pkg::RST_BYTE;
    end else begin
      if (wr_cap) begin
        capctl_reg <= wb_dat_i[7:0];
      end
      if (wr_opt) begin
        opt_reg <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sw_trig_reg <= 1'b0;
    end else begin
      sw_trig_reg <= wr_ctl1 & wb_dat_i[etp_pkg::CTL1_EST_BIT];
    end
  end

  // ------------------------------------------------------------
  // trigger and compare buffers
  // ------------------------------------------------------------
  logic ext_pulse;
  logic xfer;
  logic [CNT_W-1:0] per_reg;
  logic [CNT_W-1:0] per_buf;
  logic [CNT_W-1:0] duty_reg;
  logic [CNT_W-1:0] duty_buf;

  etp_edge_trig u_trig (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .trig_in(ext_trig_in),
    .edge_sel(trgctl_reg[1:0]),
    .trig_pulse(ext_pulse)
  );

  etp_cmp_buf #(.W(CNT_W)) u_per (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(wr_per),
    .wr_data(merge_lanes(per_reg, wb_dat_i, wb_sel_i)),
    .load(xfer),
    .reg_q(per_reg),
    .buf_q(per_buf)
  );

  etp_cmp_buf #(.W(CNT_W)) u_duty (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(wr_duty),
    .wr_data(merge_lanes(duty_reg, wb_dat_i, wb_sel_i)),
    .load(xfer),
    .reg_q(duty_reg),
    .buf_q(duty_buf)
  );

  // ------------------------------------------------------------
  // counter core
  // ------------------------------------------------------------
  etp_pkg::etp_state_t state_reg;
  etp_pkg::etp_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic pwm_reg;
  logic pwm_next;
  logic tog_reg;
  logic tog_next;
  logic dirty_reg;
  logic run_mode;
  logic running;
  logic trig;
  logic per_match;
  logic load;
  logic [CNT_W-1:0] duty_eff;
  logic irq_per_next;
  logic irq_duty_next;

  assign run_mode = ctl0_reg[etp_pkg::CTL0_CE_BIT]
    & (ctl1_reg[etp_pkg::CTL1_MD_LSB +: 3] == etp_pkg::MODE_EXT_TRIG);
  assign running = state_reg == etp_pkg::ST_RUN;
  assign trig = run_mode & (ext_pulse | sw_trig_reg);
  assign per_match = run_mode & running & (cnt_reg == per_buf);
  assign load = trig | per_match;
  // first start always loads; later clears need a fresh duty write
  assign xfer = load & (dirty_reg | ~running);
  assign duty_eff = xfer ? duty_reg : duty_buf;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      etp_pkg::ST_STOP: begin
        if (trig) begin
          state_next = etp_pkg::ST_RUN;
        end else if (run_mode) begin
          state_next = etp_pkg::ST_WAIT;
        end
      end
      etp_pkg::ST_WAIT: begin
        if (!run_mode) begin
          state_next = etp_pkg::ST_STOP;
        end else if (trig) begin
          state_next = etp_pkg::ST_RUN;
        end
      end
      default: begin
        if (!run_mode) begin
          state_next = etp_pkg::ST_STOP;
        end
      end
    endcase
  end

  always_comb begin
    if (!run_mode) begin
      cnt_next = CNT_W'(etp_pkg::CNT_IDLE);
    end else if (load) begin
      cnt_next = CNT_W'(etp_pkg::CNT_ZERO);
    end else if (running) begin
      cnt_next = cnt_reg + CNT_W'(1);
    end else begin
      cnt_next = cnt_reg;
    end
  end

  // duty match on the next count so the edge lands with the counter value
  always_comb begin
    if (!run_mode) begin
      pwm_next = 1'b0;
    end else if (load) begin
      pwm_next = duty_eff != CNT_W'(0);
    end else if (running && cnt_next == duty_buf) begin
      pwm_next = 1'b0;
    end else begin
      pwm_next = pwm_reg;
    end
  end

  assign tog_next = load ? ~tog_reg : tog_reg;

  // a trigger swallows the match events of its own cycle
  assign irq_per_next = per_match & ~trig;
  assign irq_duty_next = run_mode & running & ~trig
    & ((~load & (cnt_next == duty_buf))
       | (per_match & (duty_eff == CNT_W'(0))));

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= etp_pkg::ST_STOP;
      cnt_reg <= CNT_W'(etp_pkg::CNT_IDLE);
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwm_reg <= 1'b0;
      tog_reg <= 1'b0;
    end else begin
      pwm_reg <= pwm_next;
      tog_reg <= tog_next;
    end
  end

  // a duty write landing with the transfer keeps the flag set
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dirty_reg <= 1'b0;
    end else if (wr_duty) begin
      dirty_reg <= 1'b1;
    end else if (xfer) begin
      dirty_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // pins and events
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pins_o <= '0;
      irq_o <= '0;
    end else begin
      pins_o.pwm <= outctl_reg[etp_pkg::OUT_POE_BIT]
        & (pwm_next ^ outctl_reg[etp_pkg::OUT_POL_BIT]);
      pins_o.toggle <= outctl_reg[etp_pkg::OUT_TOE_BIT] ? tog_next
        : outctl_reg[etp_pkg::OUT_TOL_BIT];
      irq_o.period <= irq_per_next;
      irq_o.duty <= irq_duty_next;
    end
  end

  // ------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    if (wb_adr_i == etp_pkg::OFS_CTL0) begin
      rd_mux = widen8(ctl0_reg);
    end else if (wb_adr_i == etp_pkg::OFS_CTL1) begin
      rd_mux = widen8(ctl1_reg);
    end else if (wb_adr_i == etp_pkg::OFS_OUTCTL) begin
      rd_mux = widen8(outctl_reg);
    end else if (wb_adr_i == etp_pkg::OFS_CAPCTL) begin
      rd_mux = widen8(capctl_reg);
    end else if (wb_adr_i == etp_pkg::OFS_TRGCTL) begin
      rd_mux = widen8(trgctl_reg);
    end else if (wb_adr_i == etp_pkg::OFS_OPT) begin
      rd_mux = widen8(opt_reg);
    end else if (wb_adr_i == etp_pkg::OFS_PER) begin
      rd_mux[CNT_W-1:0] = per_reg;
    end else if (wb_adr_i == etp_pkg::OFS_DUTY) begin
      rd_mux[CNT_W-1:0] = duty_reg;
    end else if (wb_adr_i == etp_pkg::OFS_CNT) begin
      rd_mux[CNT_W-1:0] = cnt_reg;
    end else if (wb_adr_i == etp_pkg::OFS_STAT) begin
      rd_mux[etp_pkg::STAT_RUN_BIT] = running;
      rd_mux[etp_pkg::STAT_WAIT_BIT] = state_reg == etp_pkg::ST_WAIT;
    end
  end

  // unmapped offsets still ack, reading zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h00000000;
    end
  end
endmodule // etp_timer
`default_nettype wire

// [verification/etp_checker.sv]
`default_nettype none
module etp_checker #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // timer side
  input wire etp_pkg::etp_pins_t pins_o,
  input wire etp_pkg::etp_irq_t irq_o
);
  // --------
  // control shadow
  // --------
  // registers are not visible here, so snoop the writes
  logic [3:0] oc_reg;
  logic ce_reg;
  logic [2:0] md_reg;
  wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  wire logic run = ce_reg && md_reg == etp_pkg::MODE_EXT_TRIG;
  wire logic poe = oc_reg[etp_pkg::OUT_POE_BIT];
  wire logic toe = oc_reg[etp_pkg::OUT_TOE_BIT];
  wire logic act = pins_o.pwm != oc_reg[etp_pkg::OUT_POL_BIT];
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      oc_reg <= 4'h0;
      ce_reg <= 1'b0;
      md_reg <= 3'h0;
    end else if (wr) begin
      if (wb_adr_i == etp_pkg::OFS_OUTCTL) oc_reg <= wb_dat_i[3:0];
      if (wb_adr_i == etp_pkg::OFS_CTL0) ce_reg <= wb_dat_i[etp_pkg::CTL0_CE_BIT];
      if (wb_adr_i == etp_pkg::OFS_CTL1) md_reg <= wb_dat_i[2:0];
    end
  end
  // --------
  // properties
  // --------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
  property p_ack_lat;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
  property p_duty_lvl;
    irq_o.duty && poe && $stable(oc_reg) |-> !act;
  endproperty
  a_duty_lvl: assert property (p_duty_lvl) else $error("pwm active at duty event");
  property p_fall_duty;
    poe && run && $past(run) && $stable(oc_reg) && $past(act) && !act |-> irq_o.duty;
  endproperty
  a_fall_duty: assert property (p_fall_duty) else $error("pwm fell without duty event");
  property p_rise_tog;
    poe && toe && run && $stable(oc_reg) && !$past(act) && act |-> pins_o.toggle != $past(pins_o.toggle);
  endproperty
  a_rise_tog: assert property (p_rise_tog) else $error("pwm restart without toggle");
  property p_per_tog;
    irq_o.period && toe && $stable(oc_reg) |-> pins_o.toggle != $past(pins_o.toggle);
  endproperty
  a_per_tog: assert property (p_per_tog) else $error("period event without toggle");
  property p_irq_run;
    irq_o.period || irq_o.duty |-> run || $past(run);
  endproperty
  a_irq_run: assert property (p_irq_run) else $error("event while stopped");
  c_per: cover property (irq_o.period);
  c_duty: cover property (irq_o.duty);
  c_rd: cover property (wb_ack_o && !wb_we_i);
endmodule // etp_checker
bind etp_timer etp_checker #(.CNT_W(CNT_W)) u_chk (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pins_o, .irq_o);
`default_nettype wire

// [verification/etp_trig_src.sv]
`default_nettype none
module etp_trig_src (
  // clock
  input wire logic clk_sys,
  // trigger line
  output logic trig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial trig_o = 1'b0;
  // line idles low; edges only on the clock so spacing is exact
  task automatic train(input int hi, input int gap, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      trig_o <= 1'b1;
      repeat (hi) @(posedge clk_sys);
      trig_o <= 1'b0;
      repeat (gap) @(posedge clk_sys);
    end
  endtask
endmodule // etp_trig_src
`default_nettype wire

// [verification/tb_top.sv]
`default_nettype none
`define CHK(nm, e, a) n_compared++; if ((a) !== (e)) begin n_fail++; $display("ERROR %s exp %0h got %0h", nm, e, a); end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // signals
  // --------
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rd_q;
  logic ack;
  logic trig;
  logic pol_q = 1'b0;
  etp_pkg::etp_pins_t pins;
  etp_pkg::etp_irq_t irq;
  int n_fail = 0;
  int n_compared = 0;
  int hi_n, pi_n, di_n, fl_n;
  always #5 clk_sys = ~clk_sys;
  etp_timer #(.CNT_W(16)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ext_trig_in(trig), .pins_o(pins), .irq_o(irq));
  etp_trig_src u_src (.clk_sys(clk_sys), .trig_o(trig));
  // --------
  // tasks
  // --------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    while (ack !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd_q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    `CHK("reg read", e, rd_q)
  endtask
  task automatic cfg(input logic [15:0] per, input logic [15:0] dty, input logic [3:0] oc, input logic [1:0] eg);
    pol_q = oc[3];
    bus(etp_pkg::OFS_CTL0, 1'b1, 32'h0);
    bus(etp_pkg::OFS_OUTCTL, 1'b1, {28'h0, oc});
    bus(etp_pkg::OFS_TRGCTL, 1'b1, {30'h0, eg});
    bus(etp_pkg::OFS_PER, 1'b1, {16'h0, per});
    bus(etp_pkg::OFS_DUTY, 1'b1, {16'h0, dty});
    bus(etp_pkg::OFS_CTL1, 1'b1, 32'h2);
    bus(etp_pkg::OFS_CTL0, 1'b1, 32'h1);
  endtask
  // sampled on the falling edge so registered outputs have settled
  task automatic meas(input int n);
    logic tq;
    hi_n = 0;
    pi_n = 0;
    di_n = 0;
    fl_n = 0;
    tq = pins.toggle;
    repeat (n) begin
      hi_n += int'(pins.pwm !== pol_q);
      pi_n += int'(irq.period === 1'b1);
      di_n += int'(irq.duty === 1'b1);
      fl_n += int'(pins.toggle !== tq);
      tq = pins.toggle;
      @(negedge clk_sys);
    end
  endtask
  task automatic wait_act();
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      if (pins.pwm !== pol_q) break;
    end
  endtask
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic t_reset();
    logic [7:0] ofs[6] = '{etp_pkg::OFS_CTL0, etp_pkg::OFS_CTL1, etp_pkg::OFS_OUTCTL, etp_pkg::OFS_PER,
      etp_pkg::OFS_DUTY, 8'h3c};
    `CHK("pins", 2'b00, pins)
    bus(8'h3c, 1'b1, 32'hffff_ffff);
    bus(etp_pkg::OFS_CNT, 1'b1, 32'h1234);
    for (int i = 0; i < 6; i++) rchk(ofs[i], 32'h0);
    rchk(etp_pkg::OFS_CNT, 32'hffff);
    $display("t_reset done");
  endtask
  task automatic t_sw();
    for (int p = 0; p < 2; p++) begin
      bus(etp_pkg::OFS_CAPCTL, 1'b1, 32'hff);
      bus(etp_pkg::OFS_OPT, 1'b1, 32'hff);
      cfg(16'h3, 16'h2, {p[0], 3'b101}, etp_pkg::EDGE_NONE);
      repeat (8) @(posedge clk_sys);
      rchk(etp_pkg::OFS_CNT, 32'hffff);
      rchk(etp_pkg::OFS_STAT, 32'h2);
      `CHK("idle pwm", pol_q, pins.pwm)
      bus(etp_pkg::OFS_CTL1, 1'b1, 32'h42);
      wait_act();
      meas(16);
      `CHK("hi", 8, hi_n)
      `CHK("per irq", 3, pi_n)
      `CHK("duty irq", 4, di_n)
      `CHK("flips", 3, fl_n)
      bus(etp_pkg::OFS_CTL0, 1'b1, 32'h0);
      rchk(etp_pkg::OFS_CNT, 32'hffff);
      rchk(etp_pkg::OFS_STAT, 32'h0);
    end
    $display("t_sw done");
  endtask
  task automatic t_ext();
    int sp;
    for (int k = 0; k < 2; k++) begin
      sp = k ? 3 : 7;
      cfg(16'h9, 16'h4, 4'b0101, etp_pkg::EDGE_RISE);
      fork
        u_src.train(1, sp - 2, 6);
      join_none
      wait_act();
      meas(4 * sp);
      `CHK("hi", 4 * (sp < 4 ? sp : 4), hi_n)
      `CHK("duty irq", sp > 4 ? 4 : 0, di_n)
      `CHK("per irq", 0, pi_n)
      `CHK("flips", 3, fl_n)
      wait fork;
    end
    $display("t_ext done");
  endtask
  task automatic t_edges();
    int fl[4] = '{0, 1, 1, 2};
    for (int c = 0; c < 4; c++) begin
      cfg(16'hff, 16'h4, 4'b0101, c[1:0]);
      fork
        u_src.train(4, 2, 1);
      join_none
      @(negedge clk_sys);
      meas(20);
      `CHK("edge flips", fl[c], fl_n)
    end
    bus(etp_pkg::OFS_CTL1, 1'b1, 32'h40);
    @(negedge clk_sys);
    meas(10);
    `CHK("mode flips", 0, fl_n)
    $display("t_edges done");
  endtask
  task automatic t_buf();
    logic [7:0] ra[4] = '{etp_pkg::OFS_PER, etp_pkg::OFS_DUTY, etp_pkg::OFS_DUTY, etp_pkg::OFS_DUTY};
    logic [15:0] rv[4] = '{16'h5, 16'h2, 16'h0, 16'h6};
    int ep[4] = '{6, 4, 4, 4};
    int eh[4] = '{12, 8, 0, 24};
    int ed[4] = '{6, 4, 4, 0};
    cfg(16'h3, 16'h2, 4'b0101, etp_pkg::EDGE_NONE);
    bus(etp_pkg::OFS_CTL1, 1'b1, 32'h42);
    for (int i = 0; i < 4; i++) begin
      bus(ra[i], 1'b1, {16'h0, rv[i]});
      repeat (8) @(negedge clk_sys);
      meas(24);
      `CHK("per irq", ep[i], pi_n)
      `CHK("hi", eh[i], hi_n)
      `CHK("duty irq", ed[i], di_n)
    end
    bus(etp_pkg::OFS_CNT, 1'b0, 32'h0);
    `CHK("cnt", 1'b1, rd_q < 32'h6)
    rchk(etp_pkg::OFS_STAT, 32'h1);
    $display("t_buf done");
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_sw();
    t_ext();
    t_edges();
    t_buf();
    stop_test();
  end
  // run needs a few hundred cycles; this is generous
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
